// file: common/dcu_pkg.sv
`default_nettype none
package dcu_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_DEST   = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // channel_control field positions
  localparam int unsigned BIT_OVERRUN_SEL = 23;
  localparam int unsigned BIT_END_POL     = 22;
  localparam int unsigned BIT_ACK_CYCLE   = 17;
  localparam int unsigned BIT_ACK_POL     = 16;
  localparam int unsigned BIT_DM_HI       = 15;
  localparam int unsigned BIT_DM_LO       = 14;
  localparam int unsigned LOWER_MSB       = 13;
  localparam int unsigned LOWER_W         = 14;

  // status field positions
  localparam int unsigned ST_PENDING = 0;
  localparam int unsigned ST_HELD    = 1;
  localparam int unsigned ST_ACK     = 2;
  localparam int unsigned ST_BAD_DM  = 3;

  // reset values and reserved-bit mask
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] DEST_RESET = 32'h0000_0000;
  localparam logic [31:0] RSVD_MASK  = 32'hFF3C_0000;

  // writable bits per channel group
  localparam logic [31:0] WMASK_CH0  = 32'h00C3_FFFF;
  localparam logic [31:0] WMASK_CH1  = 32'h0083_FFFF;
  localparam logic [31:0] WMASK_CH23 = 32'h0000_FFFF;

  // address steps
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  localparam logic [31:0] STEP_16B  = 32'h0000_0010;

  typedef enum logic [1:0] {DM_FIXED, DM_INC, DM_DEC, DM_BAD} dcu_dm_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_16B} dcu_size_t;

endpackage : dcu_pkg
`default_nettype wire

// file: design/dcu_req_detect.sv
`timescale 1ns/10ps
`default_nettype none
module dcu_req_detect
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic req_n_i,
  input  wire logic enable_i,
  input  wire logic overrun_sel_i,
  input  wire logic take_i,
  output logic      pending_o,
  output logic      held_o
);

  logic sync1;
  logic sync2;
  logic prev;
  logic detect;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1 <= 1'h1;
      sync2 <= 1'h1;
      prev  <= 1'h1;
    end
    else
    begin
      sync1 <= req_n_i;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // falling edge of the active-low request
  assign detect = enable_i & prev & ~sync2;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pending_o <= 1'h0;
      held_o    <= 1'h0;
    end
    else if (take_i)
    begin
      pending_o <= held_o | detect;
      held_o    <= overrun_sel_i & held_o & detect;
    end
    else
    begin
      pending_o <= pending_o | detect;
      held_o    <= held_o | (overrun_sel_i & detect & pending_o);
    end
  end

  property p_overrun_hold;
    @(posedge clk_i) disable iff (rst_i)
    (detect && pending_o && !take_i && overrun_sel_i) |=> held_o && pending_o;
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("second request not held");

  property p_overrun_drop;
    @(posedge clk_i) disable iff (rst_i)
    (!overrun_sel_i && !held_o) |=> !held_o;
  endproperty
  a_overrun_drop: assert property (p_overrun_drop) else $error("request held in overrun 0");

endmodule : dcu_req_detect
`default_nettype wire

// file: design/dcu_addr_step.sv
`timescale 1ns/10ps
`default_nettype none
module dcu_addr_step
(
  input  wire logic [31:0]       addr_i,
  input  wire dcu_pkg::dcu_dm_t   mode_i,
  input  wire dcu_pkg::dcu_size_t size_i,
  output logic [31:0]            next_o
);

  logic [31:0] step;

  always_comb
  begin
    unique case (size_i)
      dcu_pkg::SZ_BYTE: step = dcu_pkg::STEP_BYTE;
      dcu_pkg::SZ_WORD: step = dcu_pkg::STEP_WORD;
      dcu_pkg::SZ_LONG: step = dcu_pkg::STEP_LONG;
      dcu_pkg::SZ_16B:  step = dcu_pkg::STEP_16B;
    endcase
  end

  always_comb
  begin
    unique case (mode_i)
      dcu_pkg::DM_INC: next_o = addr_i + step;
      // no decrement for 16-byte units: address holds
      dcu_pkg::DM_DEC: next_o = (size_i == dcu_pkg::SZ_16B) ? addr_i : addr_i - step;
      dcu_pkg::DM_FIXED: next_o = addr_i;
      dcu_pkg::DM_BAD:   next_o = addr_i;
    endcase
  end

endmodule : dcu_addr_step
`default_nettype wire

// file: design/dcu_channel_ctrl.sv
// Overview of operation
// - reserved bits 31-24, 21-18 read zero
// - bit 23 picks overrun 0 or 1
// - overrun/ack bits only live in channels 0,1
// - bit 22 sets transfer-end output polarity
// - end polarity absent in channels 1-3
// - dual mode: bit 17 picks read/write ack
// - single mode asserts the acknowledge in both read and write cycles
// - bit 16 sets acknowledge output polarity
// - bits 15:14 fix, increment or decrement destination
// - single mode to device ignores destination mode
`timescale 1ns/10ps
`default_nettype none
module dcu_channel_ctrl
#(
  parameter int unsigned CHAN_ID = 0
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  input  wire logic        transfer_request_in_n_i,
  input  wire logic        req_take_i,
  output logic             req_pending_o,
  input  wire logic        single_mode_i,
  input  wire logic        to_ext_dev_i,
  input  wire logic [1:0]  xfer_size_i,
  input  wire logic        read_cycle_i,
  input  wire logic        write_cycle_i,
  input  wire logic        last_xfer_i,
  input  wire logic        xfer_done_i,
  output logic             transfer_acknowledge_out_o,
  output logic             transfer_end_out_o,
  output logic [31:0]      dest_addr_o,
  output logic [13:0]      lower_ctrl_o
);

  localparam bit HAS_EXT = (CHAN_ID < 2);
  localparam bit HAS_END = (CHAN_ID == 0);

  // writable bits of channel_control for a given channel
  function automatic logic [31:0] wmask_for(input int unsigned ch);
    logic [31:0] m;
    m = dcu_pkg::WMASK_CH23;
    if (ch == 0)
    begin
      m = dcu_pkg::WMASK_CH0;
    end
    else if (ch == 1)
    begin
      m = dcu_pkg::WMASK_CH1;
    end
    return m;
  endfunction : wmask_for

  localparam logic [31:0] WMASK = wmask_for(CHAN_ID);

  logic [31:0]        channel_control;
  logic [31:0]        dest_addr;
  logic [31:0]        next_dest;
  logic               overrun_sel;
  logic               end_signal_polarity;
  logic               ack_cycle_select;
  logic               ack_polarity;
  logic               dest_addr_mode_hi;
  logic               dest_addr_mode_lo;
  dcu_pkg::dcu_dm_t   dest_mode;
  dcu_pkg::dcu_size_t xfer_size;
  logic               req_held;
  logic               ack_active;
  logic               end_active;
  logic               ack_state;
  logic               dest_frozen;
  logic               bad_dest_mode;
  logic               wr_ctrl;
  logic               wr_dest;
  logic [31:0]        status;

  assign wr_ctrl = wr_i && (addr_i == dcu_pkg::OFS_CTRL);
  assign wr_dest = wr_i && (addr_i == dcu_pkg::OFS_DEST);

  assign overrun_sel         = channel_control[dcu_pkg::BIT_OVERRUN_SEL];
  assign end_signal_polarity = channel_control[dcu_pkg::BIT_END_POL];
  assign ack_cycle_select    = channel_control[dcu_pkg::BIT_ACK_CYCLE];
  assign ack_polarity        = channel_control[dcu_pkg::BIT_ACK_POL];
  assign dest_addr_mode_hi   = channel_control[dcu_pkg::BIT_DM_HI];
  assign dest_addr_mode_lo   = channel_control[dcu_pkg::BIT_DM_LO];
  assign dest_mode           = dcu_pkg::dcu_dm_t'({dest_addr_mode_hi, dest_addr_mode_lo});
  assign xfer_size           = dcu_pkg::dcu_size_t'(xfer_size_i);

  // control register: unimplemented and reserved bits never stored
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      channel_control <= dcu_pkg::CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      channel_control <= wdata_i & WMASK;
    end
  end

  assign lower_ctrl_o = channel_control[dcu_pkg::LOWER_MSB:0];

  // external request detection, only where a request pin exists
  dcu_req_detect u_req_detect
  (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .req_n_i       (transfer_request_in_n_i),
    .enable_i      (HAS_EXT),
    .overrun_sel_i (overrun_sel),
    .take_i        (req_take_i),
    .pending_o     (req_pending_o),
    .held_o        (req_held)
  );

  // acknowledge timing
  always_comb
  begin
    ack_active = 1'h0;
    if (HAS_EXT)
    begin
      if (single_mode_i)
      begin
        ack_active = read_cycle_i | write_cycle_i;
      end
      else
      begin
        ack_active = ack_cycle_select ? write_cycle_i : read_cycle_i;
      end
    end
  end

  assign end_active = HAS_END && ack_active && last_xfer_i;

  // pin levels, registered; reset shows the idle level of a low-active pin
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      transfer_acknowledge_out_o <= 1'h1;
      ack_state                  <= 1'h0;
    end
    else
    begin
      transfer_acknowledge_out_o <= ack_active ? ack_polarity : ~ack_polarity;
      ack_state                  <= ack_active;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      transfer_end_out_o <= 1'h1;
    end
    else
    begin
      transfer_end_out_o <= end_active ? end_signal_polarity : ~end_signal_polarity;
    end
  end

  // destination address
  dcu_addr_step u_addr_step
  (
    .addr_i (dest_addr),
    .mode_i (dest_mode),
    .size_i (xfer_size),
    .next_o (next_dest)
  );

  assign dest_frozen   = single_mode_i && to_ext_dev_i;
  assign bad_dest_mode = (dest_mode == dcu_pkg::DM_BAD)
                      || ((xfer_size == dcu_pkg::SZ_16B) && (dest_mode != dcu_pkg::DM_INC));

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dest_addr <= dcu_pkg::DEST_RESET;
    end
    else if (wr_dest)
    begin
      dest_addr <= wdata_i;
    end
    else if (xfer_done_i && !dest_frozen)
    begin
      dest_addr <= next_dest;
    end
  end

  assign dest_addr_o = dest_addr;

  // status word
  always_comb
  begin
    status                        = 32'h0000_0000;
    status[dcu_pkg::ST_PENDING]   = req_pending_o;
    status[dcu_pkg::ST_HELD]      = req_held;
    status[dcu_pkg::ST_ACK]       = ack_state;
    status[dcu_pkg::ST_BAD_DM]    = bad_dest_mode;
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 32'h0000_0000;
    end
    else if (rd_i)
    begin
      unique case (addr_i)
        dcu_pkg::OFS_DEST:   rdata_o <= dest_addr;
        dcu_pkg::OFS_CTRL:   rdata_o <= channel_control & ~dcu_pkg::RSVD_MASK;
        dcu_pkg::OFS_STATUS: rdata_o <= status;
        default:             rdata_o <= 32'h0000_0000;
      endcase
    end
    else
    begin
      rdata_o <= 32'h0000_0000;
    end
  end

  property p_rsvd_read;
    @(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == dcu_pkg::OFS_CTRL) |=> (rdata_o[31:24] == 8'h00) && (rdata_o[21:18] == 4'h0);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved control bits read nonzero");

  property p_rsvd_write;
    @(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> ((channel_control & ~WMASK) == 32'h0000_0000)
             && (channel_control == ($past(wdata_i) & WMASK));
  endproperty
  a_rsvd_write: assert property (p_rsvd_write) else $error("reserved write not discarded");

  property p_chan_bits_zero;
    @(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == dcu_pkg::OFS_CTRL && CHAN_ID >= 2)
      |=> (rdata_o[23] == 1'h0) && (rdata_o[17:16] == 2'h0);
  endproperty
  a_chan_bits_zero: assert property (p_chan_bits_zero) else $error("channel-only bit read nonzero");

  property p_end_pol_zero;
    @(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == dcu_pkg::OFS_CTRL && CHAN_ID >= 1) |=> rdata_o[22] == 1'h0;
  endproperty
  a_end_pol_zero: assert property (p_end_pol_zero) else $error("end polarity read nonzero");

  property p_end_level;
    @(posedge clk_i) disable iff (rst_i)
    (HAS_END && ack_active && last_xfer_i && !wr_ctrl)
      |=> transfer_end_out_o == end_signal_polarity;
  endproperty
  a_end_level: assert property (p_end_level) else $error("transfer end level wrong");

  property p_ack_level;
    @(posedge clk_i) disable iff (rst_i)
    (!ack_active && !wr_ctrl) |=> transfer_acknowledge_out_o == !ack_polarity;
  endproperty
  a_ack_level: assert property (p_ack_level) else $error("acknowledge idle level wrong");

  property p_dual_ack;
    @(posedge clk_i) disable iff (rst_i)
    (HAS_EXT && !single_mode_i && (ack_cycle_select ? write_cycle_i : read_cycle_i))
      |=> ack_state;
  endproperty
  a_dual_ack: assert property (p_dual_ack) else $error("dual mode acknowledge missing");

  property p_dual_ack_quiet;
    @(posedge clk_i) disable iff (rst_i)
    (!single_mode_i && !ack_cycle_select && !read_cycle_i) |=> !ack_state;
  endproperty
  a_dual_ack_quiet: assert property (p_dual_ack_quiet) else $error("acknowledge outside read cycle");

  property p_single_ack;
    @(posedge clk_i) disable iff (rst_i)
    (HAS_EXT && single_mode_i && (read_cycle_i || write_cycle_i)) |=> ack_state;
  endproperty
  a_single_ack: assert property (p_single_ack) else $error("single mode acknowledge missing");

  property p_inc_16;
    @(posedge clk_i) disable iff (rst_i)
    (xfer_done_i && !wr_dest && !dest_frozen && dest_mode == dcu_pkg::DM_INC && xfer_size == dcu_pkg::SZ_16B)
      |=> dest_addr == $past(dest_addr) + dcu_pkg::STEP_16B;
  endproperty
  a_inc_16: assert property (p_inc_16) else $error("16-byte increment wrong");

  property p_dec_long;
    @(posedge clk_i) disable iff (rst_i)
    (xfer_done_i && !wr_dest && !dest_frozen && dest_mode == dcu_pkg::DM_DEC && xfer_size == dcu_pkg::SZ_LONG)
      |=> dest_addr == $past(dest_addr) - dcu_pkg::STEP_LONG;
  endproperty
  a_dec_long: assert property (p_dec_long) else $error("longword decrement wrong");

  property p_frozen;
    @(posedge clk_i) disable iff (rst_i)
    (xfer_done_i && dest_frozen && !wr_dest) |=> $stable(dest_addr);
  endproperty
  a_frozen: assert property (p_frozen) else $error("destination moved in single mode");

  property p_bad_16;
    @(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == dcu_pkg::OFS_STATUS && xfer_size == dcu_pkg::SZ_16B && dest_mode != dcu_pkg::DM_INC)
      |=> rdata_o[dcu_pkg::ST_BAD_DM];
  endproperty
  a_bad_16: assert property (p_bad_16) else $error("prohibited mode not flagged");

  property p_end_idle;
    @(posedge clk_i) disable iff (rst_i)
    ((!HAS_END || !ack_active || !last_xfer_i) && !wr_ctrl)
      |=> transfer_end_out_o == !end_signal_polarity;
  endproperty
  a_end_idle: assert property (p_end_idle) else $error("transfer end active outside last transfer");

  property p_single_ack_pin;
    @(posedge clk_i) disable iff (rst_i)
    (HAS_EXT && single_mode_i && (read_cycle_i || write_cycle_i) && !wr_ctrl)
      |=> transfer_acknowledge_out_o == ack_polarity;
  endproperty
  a_single_ack_pin: assert property (p_single_ack_pin) else $error("single mode acknowledge level wrong");

  property p_fixed;
    @(posedge clk_i) disable iff (rst_i)
    (xfer_done_i && !wr_dest && dest_mode == dcu_pkg::DM_FIXED) |=> $stable(dest_addr);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed destination moved");

  property p_inc_byte;
    @(posedge clk_i) disable iff (rst_i)
    (xfer_done_i && !wr_dest && !dest_frozen && dest_mode == dcu_pkg::DM_INC && xfer_size == dcu_pkg::SZ_BYTE)
      |=> dest_addr == $past(dest_addr) + dcu_pkg::STEP_BYTE;
  endproperty
  a_inc_byte: assert property (p_inc_byte) else $error("byte increment wrong");

  property p_ack_absent;
    @(posedge clk_i) disable iff (rst_i)
    !HAS_EXT |-> !ack_state && !req_pending_o;
  endproperty
  a_ack_absent: assert property (p_ack_absent) else $error("request or acknowledge in channel without pins");

endmodule : dcu_channel_ctrl
`default_nettype wire

// file: test/dcu_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcu_periph_model
#(
  parameter int unsigned LOW_CYC = 2
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic fire_i,
  output logic      request_n_o
);
  int unsigned cnt;

  // one falling edge per fire, then back high so the next edge is clean
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt <= 0;
    else if (fire_i && cnt == 0)
      cnt <= LOW_CYC;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end

  assign request_n_o = (cnt == 0);
endmodule : dcu_periph_model
`default_nettype wire

// file: test/test_dcu_channel_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp=%h got=%h", n, e, g); end end
module test_dcu_channel_ctrl;
  logic        clk, rst, wr, rd, fire, take, single, to_ext, rdc, wrc, last, done;
  logic        req_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [1:0]  size;
  logic [31:0] rdata [4];
  logic [31:0] dest  [4];
  logic [31:0] q     [4];
  logic [13:0] lower [4];
  logic        pend  [4];
  logic        ack   [4];
  logic        transfer_end_out  [4];
  logic        act, pol, epol;
  logic [31:0] st, ex;
  int          fail_count, total_checks;

  for (genvar g = 0; g < 4; g++)
  begin : ch
    dcu_channel_ctrl #(.CHAN_ID(g)) dcu_channel_ctrl_inst
    (
      .clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata[g]), .transfer_request_in_n_i(req_n), .req_take_i(take),
      .req_pending_o(pend[g]), .single_mode_i(single), .to_ext_dev_i(to_ext),
      .xfer_size_i(size), .read_cycle_i(rdc), .write_cycle_i(wrc), .last_xfer_i(last),
      .xfer_done_i(done), .transfer_acknowledge_out_o(ack[g]), .transfer_end_out_o(transfer_end_out[g]),
      .dest_addr_o(dest[g]), .lower_ctrl_o(lower[g])
    );
  end

  dcu_periph_model dcu_periph_model_inst
  (
    .clk_i(clk), .rst_i(rst), .fire_i(fire), .request_n_o(req_n)
  );

  function automatic logic [31:0] exp_ctrl(input int c, input logic [31:0] v);
    logic [31:0] m;
    m = ~32'hFF3C_0000;
    if (c > 0)
      m[22] = 1'b0;
    if (c > 1)
    begin
      m[23] = 1'b0;
      m[17] = 1'b0;
      m[16] = 1'b0;
    end
    return v & m;
  endfunction : exp_ctrl

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask : rd_reg

  task automatic pulse(input bit is_fire);
    @(posedge clk);
    if (is_fire)
      fire <= 1'b1;
    else
      take <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    take <= 1'b0;
  endtask : pulse

  task automatic dstep(input logic [1:0] m, input logic [1:0] s);
    wr_reg(dcu_pkg::OFS_CTRL, {16'h0000, m, 14'h0000});
    wr_reg(dcu_pkg::OFS_DEST, 32'h0000_0100);
    @(posedge clk);
    size <= s;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    rd_reg(dcu_pkg::OFS_DEST);
  endtask : dstep

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #(20 * 20000);
    fail_count++;
    end_sim();
  end

  initial
  begin
    {rst, wr, rd, fire, take, single, to_ext, rdc, wrc, last, done} = 11'h400;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    size = 2'h0;
    fail_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;

    // reset state and unmapped read
    for (int a = 0; a < 16; a += 4)
    begin
      rd_reg(a[7:0]);
      for (int g = 0; g < 4; g++)
        `CHK("read_zero", 32'h0000_0000, q[g])
    end
    for (int g = 0; g < 4; g++)
      `CHK("idle_pins", 2'h3, {ack[g], transfer_end_out[g]})
    $display("test reset done");

    // all ones: reserved and absent bits dropped per channel
    wr_reg(dcu_pkg::OFS_CTRL, 32'hFFFF_FFFF);
    rd_reg(dcu_pkg::OFS_CTRL);
    for (int g = 0; g < 4; g++)
    begin
      `CHK("ctrl", exp_ctrl(g, 32'hFFFF_FFFF), q[g])
      `CHK("lower", 14'h3FFF, lower[g])
    end
    $display("test ctrl mask done");

    // acknowledge and end pins over mode, cycle kind and polarity
    for (int m = 0; m < 16; m++)
    begin
      wr_reg(dcu_pkg::OFS_CTRL, {8'h00, 1'b0, m[2], 4'h0, m[1], m[2], 16'h4000});
      @(posedge clk);
      single <= m[0];
      rdc    <= m[3];
      wrc    <= ~m[3];
      last   <= m[1] ^ m[3];
      @(posedge clk);
      rdc <= 1'b0;
      wrc <= 1'b0;
      @(negedge clk);
      for (int g = 0; g < 4; g++)
      begin
        act  = (g < 2) && (m[0] || (m[1] ? !m[3] : m[3]));
        pol  = (g < 2) && m[2];
        epol = (g == 0) && m[2];
        `CHK("ack", act ? pol : !pol, ack[g])
        `CHK("end", (act && g == 0 && (m[1] ^ m[3])) ? epol : !epol, transfer_end_out[g])
      end
    end
    @(posedge clk);
    single <= 1'b0;
    last   <= 1'b0;
    $display("test ack pins done");

    // destination stepping for every mode and size
    for (int m = 0; m < 4; m++)
      for (int s = 0; s < 4; s++)
      begin
        dstep(m[1:0], s[1:0]);
        st = (s == 3) ? 32'h0000_0010 : (32'h0000_0001 << s);
        ex = (m == 1) ? 32'h0000_0100 + st : (m == 2 && s != 3) ? 32'h0000_0100 - st : 32'h0000_0100;
        for (int g = 0; g < 4; g++)
        begin
          `CHK("dest", ex, q[g])
          `CHK("dest_pin", ex, dest[g])
        end
        rd_reg(dcu_pkg::OFS_STATUS);
        for (int g = 0; g < 4; g++)
          `CHK("bad_dm", (m == 3 || (s == 3 && m != 1)) ? 32'h0000_0008 : 32'h0000_0000, q[g])
      end
    for (int t = 0; t < 2; t++)
    begin
      @(posedge clk);
      single <= 1'b1;
      to_ext <= t[0];
      dstep(2'h1, 2'h2);
      for (int g = 0; g < 4; g++)
        `CHK("dest_single", t ? 32'h0000_0100 : 32'h0000_0104, q[g])
    end
    @(posedge clk);
    single <= 1'b0;
    to_ext <= 1'b0;
    $display("test dest done");

    // request pin under both overrun settings
    for (int ov = 0; ov < 2; ov++)
    begin
      wr_reg(dcu_pkg::OFS_CTRL, {8'h00, ov[0], 23'h000000});
      pulse(1'b1);
      repeat (8) @(posedge clk);
      @(negedge clk);
      for (int g = 0; g < 4; g++)
        `CHK("pending", g < 2, pend[g])
      pulse(1'b1);
      repeat (8) @(posedge clk);
      pulse(1'b0);
      repeat (2) @(posedge clk);
      @(negedge clk);
      for (int g = 0; g < 4; g++)
        `CHK("held", (g < 2) && ov[0], pend[g])
      pulse(1'b0);
      repeat (2) @(posedge clk);
      @(negedge clk);
      for (int g = 0; g < 4; g++)
        `CHK("cleared", 1'b0, pend[g])
    end
    $display("test request done");
    end_sim();
  end
endmodule : test_dcu_channel_ctrl
`default_nettype wire
